// [logic/deep_sleep_defs.svh]
`ifndef DEEP_SLEEP_DEFS_SVH
`define DEEP_SLEEP_DEFS_SVH

// register word indices on the plain register port
`define DS_ADDR_CONTROL      4'h0
`define DS_ADDR_WAKE_SOURCE  4'h1
`define DS_ADDR_RESET_CTRL   4'h2
`define DS_ADDR_UNLOCK_KEY   4'h3
`define DS_ADDR_SLOW_CTRL    4'h4
`define DS_ADDR_IRQ_FLAG5    4'h5

// deep_sleep_control fields
`define DS_CTL_DEEP_ENABLE   15
`define DS_CTL_CAL_WAKE_DIS  8
`define DS_CTL_SLOW_WAKE_DIS 2
`define DS_CTL_BROWNOUT      1
`define DS_CTL_PIN_FREEZE    0
`define DS_CTL_RESET         16'h0000

// deep_sleep_wake_source fields
`define DS_WK_EXT_INT        8
`define DS_WK_FAULT          7
`define DS_WK_WATCHDOG       4
`define DS_WK_CALENDAR       3
`define DS_WK_RESET_PIN      2
`define DS_WK_POWER_ON       0
`define DS_WK_RESET          16'h0000

// reset_control_reg fields
`define DS_RC_DEEP_EXIT      10
`define DS_RC_POWER_ON       0
`define DS_RC_RESET          16'h0001

// slow_discharge_control fields
`define DS_SC_ENABLE         15
`define DS_SC_SINK           8
`define DS_SC_RESET          16'h0000

// interrupt_flag_reg_5 fields
`define DS_IF5_SLOW_WAKE     0
`define DS_IF5_RESET         16'h0000

// unlock key sequence
`define DS_KEY_FIRST         16'h0055
`define DS_KEY_SECOND        16'h00aa

// power-on sequence after a deep exit
`define DS_POR_SEQ_NS        1000
`define DS_CLK_MHZ           100

`endif

// [logic/deep_sleep_pkg.sv]
package deep_sleep_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_DEEP,
    ST_POR_SEQ
  } power_state_t;

  // asynchronous wake and supervisor events, one-cycle or level
  typedef struct packed {
    logic ext_interrupt;
    logic watchdog_timeout;
    logic calendar_alarm;
    logic reset_pin;
    logic fault;
    logic brownout;
    logic supply_power_on;
  } wake_events_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// [logic/deep_sleep_status_wake.sv]
`timescale 1ns/10ps
// How it works
// R01: deep entry sets deep exit flag, software clears
// R02: flag pair encodes other, power-on, deep exit
// R03: true power-on reset clears all deep logic
// R04: deep enable picks deep or ordinary sleep
// R05: wake-up from deep clears deep enable
// R06: software sets enable, then power-save instruction
// R07: calendar wake disable bit 8 gates alarm
// R08: slow discharge wake disable bit 2 gates
// R09: brown-out in deep sets flag at bit 1
// R10: deep brown-out never wakes the device
// R11: pin freeze hardware-set, software-cleared, holds pins
// R12: control bits reset only on true power-on
// R13: setting deep enable clears wake source register
// R14: wake causes latched at bits 8,4,3,2
// R15: fault during deep sets bit 7
// R16: power-on event sets bit 0, in any state but the power-on sequence
// R17: power-on flag survives deep-exit power-on
// R18: software clears flags, reads context, then unfreezes
// R19: software charges pin, then enables discharge wake
// R20: pin below low threshold wakes from sleep
// R21: slow discharge sleep wake sets flag bit 0
// R22: deep enable set only after 0x55, 0xaa keys
// R23: events during power-on sequence are ignored
// R24: reset-pin wake keeps registers, freeze, resets pins
// R25: deep entry sets pin freeze
// R26: unimplemented bits read zero, ignore writes
`include "deep_sleep_defs.svh"

module deep_sleep_status_wake
  import deep_sleep_pkg::*;
#(
  parameter int POR_SEQ_CYCLES =
    (`DS_POR_SEQ_NS * `DS_CLK_MHZ + 999) / 1000
)(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire reg_req_t     reg_req_in,
  output logic [15:0]       reg_rdata_out,
  input  wire logic         power_save_in,
  input  wire wake_events_t events_in,
  input  wire logic         deep_brownout_en_in,
  input  wire logic         slow_discharge_pin_in,
  output logic              sleep_active_out,
  output logic              deep_active_out,
  output logic              core_reset_out,
  output logic              pin_freeze_out,
  output logic              pin_reset_out,
  output logic              discharge_sink_out,
  output logic              sleep_wake_out
);

  localparam logic [15:0] CTL_MASK = 16'h8107;
  localparam logic [15:0] WK_MASK  = 16'h019d;
  localparam logic [15:0] SC_MASK  = 16'h8100;

  // the down-counter is 16 bits and needs at least one cycle
  if (POR_SEQ_CYCLES < 1 || POR_SEQ_CYCLES > 65535) begin : g_bad_seq
    $error("POR_SEQ_CYCLES out of range");
  end

  power_state_t state_reg;
  logic [15:0]  seq_cnt_reg;
  logic         deep_enable_reg;
  logic         cal_wake_dis_reg;
  logic         slow_wake_dis_reg;
  logic         brownout_flag_reg;
  logic         freeze_reg;
  logic [15:0]  wake_src_reg;
  logic [15:0]  wake_src_next;
  logic         deep_exit_flag_reg;
  logic         power_on_flag_reg;
  logic         slow_enable_reg;
  logic         slow_sink_reg;
  logic         slow_irq_reg;
  logic [1:0]   key_stage_reg;

  // decoded strobes
  logic wr_ctl;
  logic wr_wake;
  logic wr_rc;
  logic wr_key;
  logic wr_sc;
  logic wr_if5;
  logic [15:0] wd;

  assign wd      = reg_req_in.wdata;
  assign wr_ctl  = reg_req_in.wr && reg_req_in.addr == `DS_ADDR_CONTROL;
  assign wr_wake = reg_req_in.wr && reg_req_in.addr == `DS_ADDR_WAKE_SOURCE;
  assign wr_rc   = reg_req_in.wr && reg_req_in.addr == `DS_ADDR_RESET_CTRL;
  assign wr_key  = reg_req_in.wr && reg_req_in.addr == `DS_ADDR_UNLOCK_KEY;
  assign wr_sc   = reg_req_in.wr && reg_req_in.addr == `DS_ADDR_SLOW_CTRL;
  assign wr_if5  = reg_req_in.wr && reg_req_in.addr == `DS_ADDR_IRQ_FLAG5;

  // wake decisions in each state
  logic slow_low;
  logic deep_wake;
  logic sleep_wake;
  logic enter_deep;
  logic enter_sleep;
  logic set_deep_enable;

  // comparator only counts while the discharge circuit is enabled
  assign slow_low = slow_enable_reg && !slow_discharge_pin_in; // [R20]

  always_comb begin
    deep_wake = 1'b0;
    if (state_reg == ST_DEEP) begin
      deep_wake = events_in.ext_interrupt
               || events_in.watchdog_timeout
               || (events_in.calendar_alarm && !cal_wake_dis_reg) // [R07]
               || events_in.reset_pin
               || events_in.supply_power_on
               || (slow_low && !slow_wake_dis_reg);               // [R08]
      // brown-out is absent here on purpose: it only sets the brown-out flag and drops freeze [R10]
    end
  end

  assign sleep_wake  = state_reg == ST_SLEEP
                    && (slow_low || events_in.ext_interrupt
                        || events_in.reset_pin);
  assign enter_deep  = state_reg == ST_RUN && power_save_in
                    && deep_enable_reg;                             // [R04]
  assign enter_sleep = state_reg == ST_RUN && power_save_in
                    && !deep_enable_reg;                            // [R04]
  assign set_deep_enable = wr_ctl && wd[`DS_CTL_DEEP_ENABLE]
                        && key_stage_reg == 2'h2;                   // [R22]

  // power state sequencer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg   <= ST_RUN;
      seq_cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (enter_deep) begin
            state_reg <= ST_DEEP;
          end else if (enter_sleep) begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (sleep_wake) begin
            state_reg <= ST_RUN; // resumes with the next instruction [R20]
          end
        end
        ST_DEEP: begin
          if (deep_wake) begin
            state_reg   <= ST_POR_SEQ;
            seq_cnt_reg <= 16'(POR_SEQ_CYCLES - 1);
          end
        end
        ST_POR_SEQ: begin
          if (seq_cnt_reg == 16'h0000) begin
            state_reg <= ST_RUN;
          end else begin
            seq_cnt_reg <= seq_cnt_reg - 16'h0001;
          end
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  // unlock key: 0x55 then 0xaa arms one write to the control register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      key_stage_reg <= 2'h0;
    end else if (wr_key) begin
      if (wd == `DS_KEY_FIRST) begin
        key_stage_reg <= 2'h1;
      end else if (wd == `DS_KEY_SECOND && key_stage_reg == 2'h1) begin
        key_stage_reg <= 2'h2;                                      // [R22]
      end else begin
        key_stage_reg <= 2'h0;
      end
    end else if (reg_req_in.wr) begin
      key_stage_reg <= 2'h0; // any other write spends or breaks the key
    end
  end

  // deep_sleep_control: only the async reset (true power-on) resets it; deep wake also clears deep enable
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      deep_enable_reg   <= 1'b0;                                    // [R12]
      cal_wake_dis_reg  <= 1'b0;
      slow_wake_dis_reg <= 1'b0;
    end else begin
      if (state_reg == ST_DEEP && deep_wake) begin
        deep_enable_reg <= 1'b0;                                    // [R05]
      end else if (wr_ctl) begin
        // clearing needs no key, setting does
        deep_enable_reg <= set_deep_enable
                        || (deep_enable_reg && wd[`DS_CTL_DEEP_ENABLE]);
      end
      if (wr_ctl) begin
        cal_wake_dis_reg  <= wd[`DS_CTL_CAL_WAKE_DIS];              // [R07]
        slow_wake_dis_reg <= wd[`DS_CTL_SLOW_WAKE_DIS];             // [R08]
      end
    end
  end

  // deep brown-out flag, set wins over a software write
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      brownout_flag_reg <= 1'b0;                                    // [R03]
    end else if (state_reg == ST_DEEP && events_in.brownout
                 && deep_brownout_en_in) begin
      brownout_flag_reg <= 1'b1;                                    // [R09]
    end else if (wr_ctl) begin
      brownout_flag_reg <= wd[`DS_CTL_BROWNOUT];
    end
  end

  // pin freeze: set on deep entry, cleared only by software or brown-out
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      freeze_reg <= 1'b0;                                           // [R12]
    end else if (enter_deep) begin
      freeze_reg <= 1'b1;                                           // [R25]
    end else if (state_reg == ST_DEEP && events_in.brownout
                 && deep_brownout_en_in) begin
      freeze_reg <= 1'b0; // brown-out loses the held pin state
    end else if (wr_ctl && !wd[`DS_CTL_PIN_FREEZE]) begin
      freeze_reg <= 1'b0;                                           // [R11]
    end
  end

  // wake source: hardware sets, software writes, deep enable wipes
  always_comb begin
    wake_src_next = wake_src_reg;
    if (wr_wake) begin
      wake_src_next = wd & WK_MASK;                                 // [R26]
    end
    if (set_deep_enable) begin
      wake_src_next = 16'h0000;                                     // [R13]
    end
    // events recorded only while in deep sleep, never during power-on [R23]
    if (state_reg == ST_DEEP) begin
      if (events_in.ext_interrupt) begin
        wake_src_next[`DS_WK_EXT_INT] = 1'b1;                       // [R14]
      end
      if (events_in.watchdog_timeout) begin
        wake_src_next[`DS_WK_WATCHDOG] = 1'b1;                      // [R14]
      end
      if (events_in.calendar_alarm && !cal_wake_dis_reg) begin
        wake_src_next[`DS_WK_CALENDAR] = 1'b1;                      // [R14]
      end
      if (events_in.reset_pin) begin
        wake_src_next[`DS_WK_RESET_PIN] = 1'b1;                     // [R24]
      end
      if (events_in.fault) begin
        wake_src_next[`DS_WK_FAULT] = 1'b1;                         // [R15]
      end
    end
    // power-on flag may be set in any state but the power-on sequence, kept across deep exit
    if (events_in.supply_power_on && state_reg != ST_POR_SEQ) begin
      wake_src_next[`DS_WK_POWER_ON] = 1'b1;                        // [R16]
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_src_reg <= `DS_WK_RESET;                                 // [R17]
    end else begin
      wake_src_reg <= wake_src_next;
    end
  end

  // reset-cause pair in reset_control_reg
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      deep_exit_flag_reg <= 1'b0;
      power_on_flag_reg  <= 1'b1; // true power-on reads as normal [R02]
    end else begin
      if (enter_deep) begin
        deep_exit_flag_reg <= 1'b1;                                 // [R01]
      end else if (wr_rc) begin
        deep_exit_flag_reg <= wd[`DS_RC_DEEP_EXIT];
      end
      if (state_reg == ST_DEEP && deep_wake) begin
        power_on_flag_reg <= 1'b1; // exit looks like power-on [R02]
      end else if (wr_rc) begin
        power_on_flag_reg <= wd[`DS_RC_POWER_ON];
      end
    end
  end

  // slow discharge control and its sleep wake flag
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      slow_enable_reg <= 1'b0;
      slow_sink_reg   <= 1'b0;
      slow_irq_reg    <= 1'b0;
    end else begin
      if (wr_sc) begin
        slow_enable_reg <= wd[`DS_SC_ENABLE];
        slow_sink_reg   <= wd[`DS_SC_SINK];
      end
      if (state_reg == ST_SLEEP && slow_low) begin
        slow_irq_reg <= 1'b1;                                       // [R21]
      end else if (wr_if5) begin
        slow_irq_reg <= wd[`DS_IF5_SLOW_WAKE];
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sleep_active_out   <= 1'b0;
      deep_active_out    <= 1'b0;
      core_reset_out     <= 1'b0;
      pin_freeze_out     <= 1'b0;
      pin_reset_out      <= 1'b0;
      discharge_sink_out <= 1'b0;
      sleep_wake_out     <= 1'b0;
    end else begin
      sleep_active_out   <= state_reg == ST_SLEEP && !sleep_wake;
      deep_active_out    <= enter_deep
                         || (state_reg == ST_DEEP && !deep_wake);
      core_reset_out     <= (state_reg == ST_DEEP && deep_wake)
                         || (state_reg == ST_POR_SEQ
                             && seq_cnt_reg != 16'h0000);
      pin_freeze_out     <= freeze_reg;                             // [R11]
      // reset-pin wake puts pins in reset state, freeze kept [R24]
      pin_reset_out      <= state_reg == ST_DEEP && deep_wake
                         && events_in.reset_pin;
      discharge_sink_out <= slow_enable_reg && slow_sink_reg;
      sleep_wake_out     <= sleep_wake;
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (!reg_req_in.rd) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_req_in.addr == `DS_ADDR_CONTROL) begin
      reg_rdata_out <= CTL_MASK & {deep_enable_reg, 6'h00,
                                   cal_wake_dis_reg, 5'h00,
                                   slow_wake_dis_reg, brownout_flag_reg,
                                   freeze_reg};                     // [R26]
    end else if (reg_req_in.addr == `DS_ADDR_WAKE_SOURCE) begin
      reg_rdata_out <= wake_src_reg & WK_MASK;
    end else if (reg_req_in.addr == `DS_ADDR_RESET_CTRL) begin
      reg_rdata_out <= {5'h00, deep_exit_flag_reg, 9'h000,
                        power_on_flag_reg};
    end else if (reg_req_in.addr == `DS_ADDR_SLOW_CTRL) begin
      reg_rdata_out <= SC_MASK & {slow_enable_reg, 6'h00,
                                  slow_sink_reg, 8'h00};
    end else if (reg_req_in.addr == `DS_ADDR_IRQ_FLAG5) begin
      reg_rdata_out <= {15'h0000, slow_irq_reg};
    end else begin
      reg_rdata_out <= 16'h0000; // key and unmapped read zero
    end
  end

endmodule

// [test/deep_sleep_status_wake_asserts.sv]
`timescale 1ns/10ps
module deep_sleep_status_wake_asserts
  import deep_sleep_pkg::*;
#(
  parameter int POR_SEQ_CYCLES = 100
)(
  input wire logic         clk_in,
  input wire logic         rst_in,
  input wire reg_req_t     reg_req_in,
  input wire logic [15:0]  reg_rdata_out,
  input wire logic         power_save_in,
  input wire wake_events_t events_in,
  input wire logic         deep_brownout_en_in,
  input wire logic         slow_discharge_pin_in,
  input wire logic         sleep_active_out,
  input wire logic         deep_active_out,
  input wire logic         core_reset_out,
  input wire logic         pin_freeze_out,
  input wire logic         pin_reset_out,
  input wire logic         discharge_sink_out,
  input wire logic         sleep_wake_out
);
  logic [15:0] por_cnt_reg;

  // cycles spent so far in the power-on sequence
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      por_cnt_reg <= 16'h0000;
    end else if (core_reset_out) begin
      por_cnt_reg <= por_cnt_reg + 16'h0001;
    end else begin
      por_cnt_reg <= 16'h0000;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // a lone brown-out must not count as a wake event
  sequence bor_only_s;
    deep_active_out && events_in == 7'h02 && slow_discharge_pin_in;
  endsequence
  sequence pin_pulse_s;
    pin_reset_out ##1 !pin_reset_out;
  endsequence

  chk_deep_cause: assert property (
    $rose(deep_active_out) |-> $past(power_save_in))
    else $error("deep entry without power-save");
  chk_freeze_entry: assert property (
    $rose(deep_active_out) |=> pin_freeze_out)
    else $error("freeze not set on deep entry");
  chk_mode_onehot: assert property (
    $onehot0({deep_active_out, sleep_active_out, core_reset_out}))
    else $error("two power modes at once");
  chk_bor_nowake: assert property (
    bor_only_s |=> deep_active_out)
    else $error("brown-out woke the device");
  chk_wdt_wake: assert property (
    deep_active_out && events_in.watchdog_timeout
      |=> !deep_active_out && core_reset_out)
    else $error("watchdog did not wake");
  chk_pin_reset: assert property (
    deep_active_out && events_in.reset_pin |=> pin_pulse_s)
    else $error("reset pin pulse wrong");
  chk_por_bound: assert property (
    core_reset_out |-> int'(por_cnt_reg) < POR_SEQ_CYCLES)
    else $error("power-on sequence too long");
  chk_por_length: assert property (
    $fell(core_reset_out) |-> int'(por_cnt_reg) == POR_SEQ_CYCLES)
    else $error("power-on sequence too short");
  chk_sleep_wake: assert property (
    $rose(sleep_wake_out) |-> $fell(sleep_active_out))
    else $error("sleep wake without leaving sleep");
  chk_read_idle: assert property (
    reg_rdata_out != 16'h0000 |-> $past(reg_req_in.rd))
    else $error("read data outside read slot");
endmodule

// [test/deep_sleep_status_wake_test.sv]
`timescale 1ns/10ps
module deep_sleep_status_wake_test
  import deep_sleep_pkg::*;
;
  localparam int POR_CYC = 4;
  logic         clk_in = 1'b0;
  logic         rst_in = 1'b1;
  reg_req_t     req = '0;
  logic         psave = 1'b0;
  wake_events_t ev = '0;
  logic         bor_en = 1'b1;
  logic         pin = 1'b1;
  logic [15:0]  rdata;
  logic         sleep_a, deep_a, core_rst, frz, sink, swake, prst;
  int           mismatches = 0;
  int           samples_checked = 0;

  always #5 clk_in = ~clk_in;

  deep_sleep_status_wake #(.POR_SEQ_CYCLES(POR_CYC)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .power_save_in(psave), .events_in(ev),
    .deep_brownout_en_in(bor_en), .slow_discharge_pin_in(pin),
    .sleep_active_out(sleep_a), .deep_active_out(deep_a),
    .core_reset_out(core_rst), .pin_freeze_out(frz),
    .pin_reset_out(prst), .discharge_sink_out(sink),
    .sleep_wake_out(swake));

  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e, string w);
    @(posedge clk_in);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1 check(w, rdata, e);
  endtask

  // one power-save pulse, then both mode flags two edges on
  task automatic save(input logic deep);
    @(posedge clk_in);
    psave <= 1'b1;
    @(posedge clk_in);
    psave <= 1'b0;
    // sleep flag follows the state, one cycle behind the deep flag
    @(posedge clk_in);
    #1 check("mode", {deep_a, sleep_a}, {deep, !deep});
  endtask

  // bounded wait for the power-on sequence to end
  task automatic wait_por;
    for (int n = 0; n < 50 && core_rst !== 1'b0; n++) begin
      @(posedge clk_in);
      #1;
    end
    if (core_rst !== 1'b0) begin
      mismatches++;
      give_verdict();
    end
  endtask

  // key, enable, enter deep, fire events, wake, inspect, clean up
  task automatic deep_run(input logic [15:0] ctl, input wake_events_t e,
      input logic p, still, input logic [15:0] wk, cl);
    wr(4'h1, 16'hffff);
    wr(4'h3, 16'h0055);
    wr(4'h3, 16'h00aa);
    wr(4'h0, ctl | 16'h8000);
    rd(4'h1, 16'h0000, "wake cleared");
    save(1'b1);
    @(posedge clk_in);
    ev <= e;
    pin <= p;
    @(posedge clk_in);
    ev <= '0;
    pin <= 1'b1;
    #1 check("pin reset", prst, e.reset_pin);
    @(posedge clk_in);
    #1 check("still deep", deep_a, still);
    // late interrupt lands inside the power-on sequence; a run still in deep gets a watchdog wake instead
    @(posedge clk_in);
    ev.ext_interrupt <= !still;
    ev.watchdog_timeout <= still;
    @(posedge clk_in);
    ev <= '0;
    wait_por();
    rd(4'h1, wk, "wake src");
    rd(4'h0, cl, "control");
    rd(4'h2, 16'h0401, "reset ctrl");
    check("freeze", frz, cl[0]);
    wr(4'h2, 16'h0001);
    rd(4'h2, 16'h0001, "exit cleared");
    wr(4'h0, 16'h0000);
    // the freeze pin is a registered copy, one edge behind the bit
    @(posedge clk_in);
    #1 check("unfrozen", frz, 1'b0);
  endtask

  // reset values, key refusal, write masks, power-on flag
  task automatic reg_test;
    rd(4'h0, 16'h0000, "ctl reset");
    rd(4'h1, 16'h0000, "wake reset");
    rd(4'h2, 16'h0001, "rc reset");
    rd(4'hf, 16'h0000, "unmapped");
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'h0106, "no key");
    wr(4'h1, 16'hffff);
    rd(4'h1, 16'h019d, "wake bits");
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h0000);
    @(posedge clk_in);
    ev.supply_power_on <= 1'b1;
    @(posedge clk_in);
    ev <= '0;
    rd(4'h1, 16'h0001, "power-on flag");
    $display("register test done");
  endtask

  // one deep entry per wake source except supply power-on; discharge armed for the last two
  task automatic deep_test;
    deep_run(16'h0, 7'h40, 1'b1, 1'b0, 16'h0100, 16'h1);
    deep_run(16'h0, 7'h20, 1'b1, 1'b0, 16'h0010, 16'h1);
    deep_run(16'h0, 7'h10, 1'b1, 1'b0, 16'h0008, 16'h1);
    deep_run(16'h0, 7'h08, 1'b1, 1'b0, 16'h0004, 16'h1);
    deep_run(16'h0, 7'h24, 1'b1, 1'b0, 16'h0090, 16'h1);
    deep_run(16'h100, 7'h10, 1'b1, 1'b1, 16'h10, 16'h101);
    deep_run(16'h0, 7'h02, 1'b1, 1'b1, 16'h0010, 16'h2);
    // without the comparator enabled the disable bit proves nothing
    wr(4'h4, 16'h8100);
    @(posedge clk_in);
    #1 check("sink", sink, 1'b1);
    deep_run(16'h4, 7'h00, 1'b0, 1'b1, 16'h0010, 16'h5);
    deep_run(16'h0, 7'h00, 1'b0, 1'b0, 16'h0000, 16'h1);
    $display("deep test done");
  endtask

  // ordinary sleep left by the discharge comparator
  task automatic sleep_test;
    save(1'b0);
    @(posedge clk_in);
    pin <= 1'b0;
    @(posedge clk_in);
    #1 check("sleep wake", {swake, sleep_a}, 2'b10);
    @(posedge clk_in);
    pin <= 1'b1;
    rd(4'h5, 16'h0001, "sleep flag");
    $display("sleep test done");
  endtask

  // a second true power-on in mid-run clears everything again
  task automatic reset_test;
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(4'h4, 16'h0000, "slow reset");
    rd(4'h5, 16'h0000, "flag5 reset");
    rd(4'h2, 16'h0001, "rc power-on");
    $display("reset test done");
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    reg_test();
    deep_test();
    sleep_test();
    reset_test();
    give_verdict();
  end
endmodule

bind deep_sleep_status_wake deep_sleep_status_wake_asserts #(
  .POR_SEQ_CYCLES(POR_SEQ_CYCLES)
) i_chk (
  .clk_in(clk_in), .rst_in(rst_in), .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out), .power_save_in(power_save_in),
  .events_in(events_in), .deep_brownout_en_in(deep_brownout_en_in),
  .slow_discharge_pin_in(slow_discharge_pin_in),
  .sleep_active_out(sleep_active_out),
  .deep_active_out(deep_active_out), .core_reset_out(core_reset_out),
  .pin_freeze_out(pin_freeze_out), .pin_reset_out(pin_reset_out),
  .discharge_sink_out(discharge_sink_out),
  .sleep_wake_out(sleep_wake_out));
